// ---- pkg/apc_regs.vh ----
// apc_regs.vh: register indices, field positions, reset values and port
// addresses of the attribute palette controller.
// assumes: included by bare name from rtl files, no code here.
`ifndef APC_REGS_VH
`define APC_REGS_VH

// host i/o port addresses
`define APC_PORT_ATTR      16'h03C0
`define APC_PORT_ATTR_RD   16'h03C1
`define APC_PORT_EXT_DATA  16'h03C5
`define APC_PORT_STAT_MONO 16'h03BA
`define APC_PORT_STAT_COL  16'h03DA
`define APC_PORT_CRT_MONO  16'h03B5
`define APC_PORT_CRT_COL   16'h03D5

// extension and crt controller indices that mirror the attribute index
`define APC_EXT_IDX_ATTR   8'h83
`define APC_CRT_IDX_ATTR   8'h24

// attribute data register indices
`define APC_IDX_PAL_LAST   5'h0F
`define APC_IDX_MODE       5'h10
`define APC_IDX_BORDER     5'h11
`define APC_IDX_PLANE_EN   5'h12
`define APC_IDX_PAN        5'h13
`define APC_IDX_CSEL       5'h14

// attribute index fields
`define APC_AIX_SEL_MSB    4
`define APC_AIX_PAS        5

// mode control fields
`define APC_MC_GFX         0
`define APC_MC_MONO        1
`define APC_MC_LINEGFX     2
`define APC_MC_BLINK       3
`define APC_MC_PANCOMPAT   5
`define APC_MC_PIXWIDTH    6
`define APC_MC_ALTSRC      7

// line graphics character code range
`define APC_LINE_LO        8'hC0
`define APC_LINE_HI        8'hDF

// reset values
`define APC_RST_INDEX      6'h00
`define APC_RST_MODE       8'h00
`define APC_RST_BORDER     8'h00
`define APC_RST_PLANE_EN   6'h0F
`define APC_RST_PAN        4'h0
`define APC_RST_CSEL       4'h0
`define APC_RST_RDATA      8'h00
`define APC_RST_VIDEO      8'h00

// blink divider width: phase flips every 16 frames
`define APC_BLINK_W        5

`endif

// ---- rtl/apc_blink_gen.v ----
// apc_blink_gen: blink phase generator, one step per vertical retrace
// start. assumes vRetrace is a level from logic on the same dot clock.
`timescale 1ns/1ps
`default_nettype none
`include "apc_regs.vh"

module apc_blink_gen
(
	// clock and reset
	input  wire       clk,
	input  wire       resetn,
	// retrace level from the crt timing logic
	input  wire       vRetrace,
	// blink phase, high in the second half of the period
	output wire       blinkPhase
);

	reg                       retraceDly_ff;
	reg [`APC_BLINK_W-1:0]    blinkCnt_ff;
	wire                      retraceStart;

	// rising edge of retrace marks one frame
	assign retraceStart = vRetrace & ~retraceDly_ff;

	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			retraceDly_ff <= 1'b0;
			blinkCnt_ff   <= {`APC_BLINK_W{1'b0}};
		end
		else
		begin
			retraceDly_ff <= vRetrace;
			if (retraceStart)
				blinkCnt_ff <= blinkCnt_ff + 1'b1;
		end
	end

	// msb gives 16 frames per state
	assign blinkPhase = blinkCnt_ff[`APC_BLINK_W-1];

endmodule // apc_blink_gen

`default_nettype wire

// ---- rtl/apc_attr_ctrl.v ----
// apc_attr_ctrl: attribute palette controller, maps each pixel outside
// 256-colour mode through sixteen palette entries to an 8-bit dac index.
// assumes: host i/o strobes, crt timing and pixel data all on clk.
//
// How it works
// - five low index bits pick data register
// - shared port alternates index and data writes
// - status read resets pointer to index
// - extension index 83 reads index plus pointer
// - crt index 24 also reads attribute index
// - address source 0 shows overscan colour
// - sixteen entries map pixel to colour
// - eight-bit colour value per pixel to dac
// - alternate source picks bits 5 and 4
// - 256-colour mode ignores alternate source
// - pixel width halves shifter, bypasses palette
// - pan compatibility pans upper screen only
// - blink every 16 frames when enabled
// - line graphics copies eighth dot ninth
// - mono bit clears palette input bit1 in graphics mode
// - graphics mode bit selects text or graphics
// - graphics blink without mono clears palette input bit3 in second phase
// - text attribute bit7 intensity or blink
// - overscan colour outside blank and display
// - colour select drives output bits 7, 6
`timescale 1ns/1ps
`default_nettype none
`include "apc_regs.vh"

module apc_attr_ctrl
(
	// clock and reset
	input  wire        clk,
	input  wire        resetn,
	// host i/o port access
	input  wire [15:0] ioAddr,
	input  wire        ioWr,
	input  wire        ioRd,
	input  wire [7:0]  ioWrData,
	output reg  [7:0]  ioRdData,
	output reg         ioRdHit,
	// indices held by the sequencer and crt controller
	input  wire [7:0]  extIndex,
	input  wire [7:0]  crtIndex,
	// crt timing
	input  wire        vRetrace,
	input  wire        displayEn,
	input  wire        blank,
	input  wire        lowerScreen,
	// text pixel stream
	input  wire        textFontDot,
	input  wire        textNinth,
	input  wire [7:0]  textCode,
	input  wire [7:0]  textAttr,
	// graphics pixel stream
	input  wire [3:0]  planeData,
	input  wire [7:0]  pix256,
	// to the external dac and the shifter
	output reg  [7:0]  dacIndex,
	output reg         shiftHalf,
	output reg  [3:0]  panCount,
	output reg  [1:0]  diagBits
);

	// register file
	reg  [5:0]  attrIndex_ff;
	reg         dataPtr_ff;
	reg  [7:0]  palette_ff [0:15];
	reg  [7:0]  modeCtl_ff;
	reg  [7:0]  border_ff;
	reg  [5:0]  planeEn_ff;
	reg  [3:0]  panShift_ff;
	reg  [3:0]  colourSel_ff;
	reg         eighthDot_ff;

	// next values
	reg  [7:0]  nxt_rdData;
	reg         nxt_rdHit;
	reg  [3:0]  nxt_palAddr;
	reg  [7:0]  nxt_video;
	reg         fgOn;
	reg  [3:0]  bgColour;
	reg  [7:0]  palOut;

	wire        blinkPhase;
	wire [4:0]  dataSel;
	wire        palHost;
	wire        blinkEn;
	wire        gfxMode;
	wire        monoAttr;
	wire        lineGfx;
	wire        pixWidth;
	wire        altSrc;
	wire        isLineChar;
	wire        attrPortWr;
	wire        statusRd;
	integer     i;

	// data register select from low index bits
	assign dataSel  = attrIndex_ff[`APC_AIX_SEL_MSB:0];
	// palette source bit, 0 gives host ownership
	assign palHost  = ~attrIndex_ff[`APC_AIX_PAS];
	assign gfxMode  = modeCtl_ff[`APC_MC_GFX];
	assign monoAttr = modeCtl_ff[`APC_MC_MONO];
	assign lineGfx  = modeCtl_ff[`APC_MC_LINEGFX];
	assign blinkEn  = modeCtl_ff[`APC_MC_BLINK];
	assign pixWidth = modeCtl_ff[`APC_MC_PIXWIDTH];
	assign altSrc   = modeCtl_ff[`APC_MC_ALTSRC];

	// port decodes
	assign attrPortWr = ioWr & (ioAddr == `APC_PORT_ATTR);
	assign statusRd   = ioRd & ((ioAddr == `APC_PORT_STAT_MONO) |
		(ioAddr == `APC_PORT_STAT_COL));

	// character codes that extend into the ninth dot
	assign isLineChar = (textCode >= `APC_LINE_LO) &
		(textCode <= `APC_LINE_HI);

	// blink phase source
	apc_blink_gen u_blink
	(
		.clk        (clk),
		.resetn     (resetn),
		.vRetrace   (vRetrace),
		.blinkPhase (blinkPhase)
	);

	// host writes and the index/data pointer
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			dataPtr_ff   <= 1'b0;
			attrIndex_ff <= `APC_RST_INDEX;
			modeCtl_ff   <= `APC_RST_MODE;
			border_ff    <= `APC_RST_BORDER;
			planeEn_ff   <= `APC_RST_PLANE_EN;
			panShift_ff  <= `APC_RST_PAN;
			colourSel_ff <= `APC_RST_CSEL;
			for (i = 0; i < 16; i = i + 1)
				palette_ff[i] <= i[7:0];
		end
		else if (statusRd)
		begin
			dataPtr_ff <= 1'b0;
		end
		else if (attrPortWr)
		begin
			dataPtr_ff <= ~dataPtr_ff;
			if (!dataPtr_ff)
				attrIndex_ff <= ioWrData[5:0];
			else if (dataSel <= `APC_IDX_PAL_LAST)
			begin
				// palette writes only while host owns it
				if (palHost)
					palette_ff[dataSel[3:0]] <= ioWrData;
			end
			else
			begin
				case (dataSel)
					`APC_IDX_MODE:     modeCtl_ff   <= ioWrData;
					`APC_IDX_BORDER:   border_ff    <= ioWrData;
					`APC_IDX_PLANE_EN: planeEn_ff   <= ioWrData[5:0];
					`APC_IDX_PAN:      panShift_ff  <= ioWrData[3:0];
					`APC_IDX_CSEL:     colourSel_ff <= ioWrData[3:0];
					default:           modeCtl_ff   <= modeCtl_ff;
				endcase
			end
		end
	end

	// read data selection, answered one clock after the strobe
	always @*
	begin
		nxt_rdData = `APC_RST_RDATA;
		nxt_rdHit  = 1'b0;
		if (ioRd)
		begin
			case (ioAddr)
				`APC_PORT_ATTR:
				begin
					nxt_rdData = {2'b00, attrIndex_ff};
					nxt_rdHit  = 1'b1;
				end
				`APC_PORT_ATTR_RD:
				begin
					nxt_rdHit = 1'b1;
					if (dataSel <= `APC_IDX_PAL_LAST)
						nxt_rdData = palette_ff[dataSel[3:0]];
					else
					begin
						case (dataSel)
							`APC_IDX_MODE:     nxt_rdData = modeCtl_ff;
							`APC_IDX_BORDER:   nxt_rdData = border_ff;
							`APC_IDX_PLANE_EN:
								nxt_rdData = {2'b00, planeEn_ff};
							`APC_IDX_PAN:
								nxt_rdData = {4'h0, panShift_ff};
							`APC_IDX_CSEL:
								nxt_rdData = {4'h0, colourSel_ff};
							default:           nxt_rdData = `APC_RST_RDATA;
						endcase
					end
				end
				`APC_PORT_EXT_DATA:
				begin
					// index with pointer state in bit 7
					if (extIndex == `APC_EXT_IDX_ATTR)
					begin
						nxt_rdData = {dataPtr_ff, 1'b0, attrIndex_ff};
						nxt_rdHit  = 1'b1;
					end
				end
				`APC_PORT_CRT_MONO, `APC_PORT_CRT_COL:
				begin
					// mirror of the index in crt space
					if (crtIndex == `APC_CRT_IDX_ATTR)
					begin
						nxt_rdData = {2'b00, attrIndex_ff};
						nxt_rdHit  = 1'b1;
					end
				end
				default:
				begin
					nxt_rdData = `APC_RST_RDATA;
					nxt_rdHit  = 1'b0;
				end
			endcase
		end
	end

	// palette input formation for text and graphics
	always @*
	begin
		nxt_palAddr = 4'h0;
		fgOn        = 1'b0;
		bgColour    = 4'h0;
		if (!gfxMode)
		begin
			// ninth dot copies eighth for line chars
			if (textNinth)
				fgOn = lineGfx & isLineChar & eighthDot_ff;
			else
				fgOn = textFontDot;
			// bit 7 is intensity or blink control
			if (blinkEn)
			begin
				bgColour = {1'b0, textAttr[6:4]};
				if (textAttr[7] & blinkPhase)
					fgOn = 1'b0;
			end
			else
				bgColour = textAttr[7:4];
			nxt_palAddr = fgOn ? textAttr[3:0] : bgColour;
		end
		else
		begin
			nxt_palAddr = planeData;
			// mono patterns on planes 0 and 2
			if (monoAttr)
			begin
				nxt_palAddr[1] = 1'b0;
				nxt_palAddr[3] = planeData[3] ^ blinkPhase;
			end
			else if (blinkEn)
			begin
				// plane 3 set gives blinking bit3
				nxt_palAddr[3] = planeData[3] & ~blinkPhase;
			end
		end
		// plane enable masks the palette input
		nxt_palAddr = nxt_palAddr & planeEn_ff[3:0];
	end

	// output colour build
	always @*
	begin
		palOut    = palette_ff[nxt_palAddr];
		nxt_video = `APC_RST_VIDEO;
		if (palHost)
			nxt_video = border_ff;
		else if (!displayEn)
		begin
			// overscan when neither blank nor display
			if (!blank)
				nxt_video = border_ff;
		end
		else if (pixWidth)
			// bypass palette, all 8 bits out
			nxt_video = pix256;
		else
		begin
			nxt_video[7:6] = colourSel_ff[3:2];
			// bits 5 and 4 source select
			nxt_video[5:4] = altSrc ? colourSel_ff[1:0] : palOut[5:4];
			nxt_video[3:0] = palOut[3:0];
		end
	end

	// registered outputs and pixel history
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ioRdData     <= `APC_RST_RDATA;
			ioRdHit      <= 1'b0;
			dacIndex     <= `APC_RST_VIDEO;
			shiftHalf    <= 1'b0;
			panCount     <= `APC_RST_PAN;
			diagBits     <= 2'b00;
			eighthDot_ff <= 1'b0;
		end
		else
		begin
			ioRdData  <= nxt_rdData;
			ioRdHit   <= nxt_rdHit;
			dacIndex  <= nxt_video;
			shiftHalf <= pixWidth;
			// lower screen unpanned in compat mode
			if (modeCtl_ff[`APC_MC_PANCOMPAT] & lowerScreen)
				panCount <= `APC_RST_PAN;
			else
				panCount <= panShift_ff;
			// diagnostic pair of video bits
			case (planeEn_ff[5:4])
				2'b00:   diagBits <= {nxt_video[2], nxt_video[0]};
				2'b01:   diagBits <= {nxt_video[5], nxt_video[4]};
				2'b10:   diagBits <= {nxt_video[3], nxt_video[1]};
				default: diagBits <= {nxt_video[7], nxt_video[6]};
			endcase
			// last foreground dot for the ninth column
			if (!textNinth)
				eighthDot_ff <= textFontDot;
		end
	end

endmodule // apc_attr_ctrl

`default_nettype wire

// ---- bench/apc_attr_properties.sv ----
// apc_attr_props: port checker for the attribute palette controller.
// assumes: bound to apc_attr_ctrl, every signal on clk.
`timescale 1ns/1ps
`default_nettype none
module apc_attr_props
(
	// clock and reset
	input wire logic        clk,
	input wire logic        resetn,
	// host port
	input wire logic [15:0] ioAddr,
	input wire logic        ioWr,
	input wire logic        ioRd,
	input wire logic [7:0]  ioWrData,
	input wire logic [7:0]  ioRdData,
	input wire logic        ioRdHit,
	input wire logic [7:0]  extIndex,
	input wire logic [7:0]  crtIndex,
	// video
	input wire logic        displayEn,
	input wire logic        blank,
	input wire logic        lowerScreen,
	input wire logic [7:0]  pix256,
	input wire logic [7:0]  dacIndex,
	input wire logic [3:0]  panCount
);
	logic       ptr_ff;
	logic [5:0] idx_ff;
	logic [7:0] mode_ff, bord_ff, csel_ff;
	wire stat = ioRd && (ioAddr == 16'h03BA || ioAddr == 16'h03DA);
	wire aw = ioWr && ioAddr == 16'h03C0 && !stat;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// shadow of pointer and registers built from host traffic
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ptr_ff <= 1'b0;
			idx_ff <= 6'h00;
			mode_ff <= 8'h00;
			bord_ff <= 8'h00;
			csel_ff <= 8'h00;
		end
		else if (stat)
			ptr_ff <= 1'b0;
		else if (aw)
		begin
			ptr_ff <= !ptr_ff;
			if (!ptr_ff) idx_ff <= ioWrData[5:0];
			else if (idx_ff[4:0] == 5'h10) mode_ff <= ioWrData;
			else if (idx_ff[4:0] == 5'h11) bord_ff <= ioWrData;
			else if (idx_ff[4:0] == 5'h14) csel_ff <= ioWrData;
		end
	end
	AST_RD_IDLE: assert property (!ioRdHit |-> ioRdData == 8'h00)
		else $error("read data not zero without hit");
	AST_ATTR_RD: assert property (ioRd && ioAddr == 16'h03C1 |=> ioRdHit)
		else $error("data port read missed");
	AST_EXT_RD: assert property (ioRd && ioAddr == 16'h03C5 &&
		extIndex == 8'h83 |=> ioRdHit &&
		ioRdData == {$past(ptr_ff), 1'b0, $past(idx_ff)})
		else $error("extension index read wrong");
	AST_CRT_RD: assert property (ioRd && ioAddr == 16'h03D5 &&
		crtIndex == 8'h24 |=> ioRdData == {2'b00, $past(idx_ff)})
		else $error("crt index read wrong");
	AST_HOST_SRC: assert property (!idx_ff[5] |=>
		dacIndex == $past(bord_ff))
		else $error("host source not showing border");
	AST_OVERSCAN: assert property (idx_ff[5] && !displayEn && !blank
		|=> dacIndex == $past(bord_ff))
		else $error("overscan colour wrong");
	AST_PASS256: assert property (idx_ff[5] && displayEn &&
		mode_ff[6] |=> dacIndex == $past(pix256))
		else $error("pass-through pixel wrong");
	AST_CSEL_HI: assert property (idx_ff[5] && displayEn &&
		!mode_ff[6] |=> dacIndex[7:6] == $past(csel_ff[3:2]))
		else $error("output bits 7:6 wrong");
	AST_ALT_SRC: assert property (idx_ff[5] && displayEn &&
		!mode_ff[6] && mode_ff[7] |=>
		dacIndex[5:4] == $past(csel_ff[1:0]))
		else $error("alternate source bits wrong");
	AST_PAN_LOWER: assert property (mode_ff[5] && lowerScreen
		|=> panCount == 4'h0)
		else $error("lower screen panned");
	AST_BLANK_BLACK: assert property (idx_ff[5] && !displayEn && blank
		|=> dacIndex == 8'h00)
		else $error("blanked pixel not black");
	COV_PASS: cover property (idx_ff[5] && mode_ff[6] && displayEn);
	COV_PTR: cover property (ioRdHit && ioRdData[7]);
	COV_PAN: cover property (mode_ff[5] && lowerScreen);
	COV_BLANK: cover property (idx_ff[5] && !displayEn && blank);
endmodule // apc_attr_props
bind apc_attr_ctrl apc_attr_props u_props (.clk(clk), .resetn(resetn),
	.ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd), .ioWrData(ioWrData),
	.ioRdData(ioRdData), .ioRdHit(ioRdHit), .extIndex(extIndex),
	.crtIndex(crtIndex), .displayEn(displayEn), .blank(blank),
	.lowerScreen(lowerScreen), .pix256(pix256), .dacIndex(dacIndex),
	.panCount(panCount));
`default_nettype wire

// ---- bench/apc_dac_model.sv ----
// apc_dac_model: external colour lookup latching the 8-bit index.
// assumes: index arrives registered on the dot clock.
`timescale 1ns/1ps
`default_nettype none
module apc_dac_model
(
	// clock and reset
	input wire logic        clk,
	input wire logic        resetn,
	// index from the controller and its latched copy
	input wire logic [7:0]  dacIndex,
	output logic [7:0]      seen_ff
);
	always_ff @(posedge clk or negedge resetn)
		if (!resetn) seen_ff <= 8'h00;
		else seen_ff <= dacIndex;
endmodule // apc_dac_model
`default_nettype wire

// ---- bench/tb_top.sv ----
// tb_top: directed bench for the attribute palette controller.
// assumes: design, checker bind and dac model compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk = 0, resetn = 0, ioWr = 0, ioRd = 0, vRetrace = 0;
	logic        displayEn = 1, lowerScreen = 0, textFontDot = 1;
	logic [15:0] ioAddr = 16'h0000;
	logic [7:0]  ioWrData = 8'h00, extIndex = 8'h83, textAttr = 8'h03;
	logic [7:0]  pix256 = 8'h5A, ioRdData, dacIndex, seen;
	logic        ioRdHit, shiftHalf, textNinth = 0, blank = 0;
	logic [7:0]  crtIndex = 8'h24, textCode = 8'h00;
	logic [3:0]  panCount, planeData = 4'h0;
	logic [1:0]  diagBits;
	int          err_total = 0, cmp_count = 0;
	// dot clock
	always #12.5 clk = ~clk;
	apc_attr_ctrl dut_u (.clk(clk), .resetn(resetn), .ioAddr(ioAddr),
		.ioWr(ioWr), .ioRd(ioRd), .ioWrData(ioWrData),
		.ioRdData(ioRdData), .ioRdHit(ioRdHit), .extIndex(extIndex),
		.crtIndex(crtIndex), .vRetrace(vRetrace), .displayEn(displayEn),
		.blank(blank), .lowerScreen(lowerScreen),
		.textFontDot(textFontDot), .textNinth(textNinth),
		.textCode(textCode), .textAttr(textAttr), .planeData(planeData),
		.pix256(pix256), .dacIndex(dacIndex), .shiftHalf(shiftHalf),
		.panCount(panCount), .diagBits(diagBits));
	apc_dac_model dac_u (.clk(clk), .resetn(resetn),
		.dacIndex(dacIndex), .seen_ff(seen));
	task cmp(input string n, input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e)
		begin
			$display("mismatch %s exp %h seen %h", n, e, s);
			err_total++;
		end
	endtask
	// one strobe cycle, released after the taking edge
	task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 ioAddr = a; ioWrData = d; ioWr = w; ioRd = !w;
		@(posedge clk);
		#1 ioWr = 0; ioRd = 0;
	endtask
	task rd(input logic [15:0] a, input logic [7:0] e, input logic h);
		acc(1'b0, a, 8'h00);
		cmp("ioRdData", ioRdData, e);
		cmp("ioRdHit", {7'h00, ioRdHit}, {7'h00, h});
	endtask
	task wrp(input logic [7:0] i, input logic [7:0] d);
		acc(1'b1, 16'h03C0, i);
		acc(1'b1, 16'h03C0, d);
	endtask
	task sr;
		acc(1'b0, 16'h03DA, 8'h00);
	endtask
	task vchk(input logic [7:0] e);
		repeat (2) @(posedge clk);
		#1 cmp("dacIndex", dacIndex, e);
		cmp("dacModel", seen, e);
	endtask
	task pulse;
		repeat (16)
		begin
			@(posedge clk);
			#1 vRetrace = 1;
			@(posedge clk);
			#1 vRetrace = 0;
		end
	endtask
	task t_ptr;
		sr;
		rd(16'h03C0, 8'h00, 1);
		acc(1'b1, 16'h03C0, 8'h12);
		rd(16'h03C1, 8'h0F, 1);
		rd(16'h03C5, 8'h92, 1);
		sr;
		rd(16'h03C5, 8'h12, 1);
		rd(16'h03D5, 8'h12, 1);
		rd(16'h03B5, 8'h12, 1);
		extIndex = 8'h00;
		rd(16'h03C5, 8'h00, 0);
		extIndex = 8'h83;
		$display("test pointer done");
	endtask
	task t_pal;
		sr;
		wrp(8'h03, 8'h2A);
		wrp(8'h23, 8'h15);
		rd(16'h03C1, 8'h2A, 1);
		vchk(8'h2A);
		wrp(8'h34, 8'h0F);
		vchk(8'hEA);
		wrp(8'h30, 8'h80);
		vchk(8'hFA);
		wrp(8'h03, 8'h03);
		wrp(8'h30, 8'hC0);
		vchk(8'h5A);
		cmp("shiftHalf", {7'h00, shiftHalf}, 8'h01);
		wrp(8'h31, 8'h77);
		displayEn = 0;
		vchk(8'h77);
		displayEn = 1;
		wrp(8'h11, 8'h77);
		vchk(8'h77);
		$display("test palette done");
	endtask
	task t_blink;
		sr;
		wrp(8'h30, 8'h08);
		textAttr = 8'h83;
		vchk(8'hC3);
		pulse;
		vchk(8'hC0);
		pulse;
		vchk(8'hC3);
		wrp(8'h30, 8'h00);
		textFontDot = 0;
		vchk(8'hC8);
		textFontDot = 1;
		$display("test blink done");
	endtask
	task t_pan;
		sr;
		wrp(8'h33, 8'h05);
		wrp(8'h30, 8'h20);
		lowerScreen = 1;
		vchk(8'hC3);
		cmp("panCount", {4'h0, panCount}, 8'h00);
		lowerScreen = 0;
		vchk(8'hC3);
		cmp("panCount", {4'h0, panCount}, 8'h05);
		$display("test pan done");
	endtask
	// line graphics, graphics blink, mono, diagnostics, blanking
	task t_gfx;
		sr;
		wrp(8'h30, 8'h04);
		textNinth = 1;
		textFontDot = 0;
		textCode = 8'hC5;
		vchk(8'hC3);
		textCode = 8'h00;
		vchk(8'hC8);
		textNinth = 0;
		textFontDot = 1;
		planeData = 4'hD;
		wrp(8'h30, 8'h01);
		vchk(8'hCD);
		cmp("shiftHalf", {7'h00, shiftHalf}, 8'h00);
		cmp("diagBits", {6'h00, diagBits}, 8'h03);
		wrp(8'h30, 8'h09);
		pulse;
		vchk(8'hC5);
		planeData = 4'hF;
		wrp(8'h30, 8'h03);
		vchk(8'hC5);
		pulse;
		vchk(8'hCD);
		wrp(8'h32, 8'h1F);
		vchk(8'hCD);
		cmp("diagBits", {6'h00, diagBits}, 8'h00);
		displayEn = 0;
		blank = 1;
		vchk(8'h00);
		displayEn = 1;
		blank = 0;
		crtIndex = 8'h00;
		rd(16'h03D5, 8'h00, 0);
		crtIndex = 8'h24;
		$display("test graphics done");
	endtask
	task wrap_up;
		$display("counts: %0d compares, %0d mismatches", cmp_count,
			err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// main sequence
	initial
	begin
		repeat (10) @(posedge clk);
		#1 resetn = 1;
		t_ptr;
		t_pal;
		t_blink;
		t_pan;
		t_gfx;
		wrap_up;
	end
	// hang guard
	initial
	begin
		#2000000;
		err_total++;
		wrap_up;
	end
endmodule // tb_top
`default_nettype wire
